/* File: hw/dsp_pkg.sv */
// Shared constants of the double-data-rate burst SRAM port
package dsp_pkg;
  // ==========================================================
  // Data organisation
  // ==========================================================
  localparam int LANE_W = 9; // One byte lane, parity bit included
  localparam int DW_X18 = 18; // Narrow organisation, two lanes
  localparam int DW_X36 = 36; // Wide organisation, four lanes
  localparam int DEF_AW = 20; // Burst address width
  // ==========================================================
  // Pipeline and buffering
  // ==========================================================
  localparam int RD_PIPE = 3; // True-clock rises from read command to drive
  localparam logic [1:0] BURST_WORDS = 2'h2; // Words per burst
  localparam int FIFO_DEPTH = 4; // Read word buffer depth
endpackage

/* File: hw/dsp_stream_if.sv */
// Valid/ready word stream between the port logic and its buffer
interface dsp_stream_if #(parameter int W = 18);
  logic valid; // Word offered
  logic ready; // Word accepted
  logic [W-1:0] data; // Word value
  // Producer end
  modport tx (output valid, output data, input ready);
  // Consumer end
  modport rx (input valid, input data, output ready);
endinterface

/* File: hw/dsp_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
module dsp_fifo #(
  parameter int W = 18,
  parameter int D = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  dsp_stream_if.rx in_s,
  // Drain side
  dsp_stream_if.tx out_s
);
  localparam int PW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);
  // Depth below two gives no useful buffering
  if (D < 2 || W < 1) begin : g_bad
    $error("dsp_fifo: depth must be at least 2");
  end
  logic [W-1:0] buf_mem [D]; // Storage words
  logic [PW-1:0] wr_ptr_reg; // Next slot to fill
  logic [PW-1:0] rd_ptr_reg; // Next slot to drain
  logic [CW-1:0] cnt_reg; // Words held
  logic push; // Fill accepted
  logic pop; // Drain accepted
  // ==========================================================
  // Handshakes
  // ==========================================================
  // Full and empty come straight from the word count
  assign in_s.ready = (cnt_reg != CW'(D));
  assign out_s.valid = (cnt_reg != '0);
  assign out_s.data = buf_mem[rd_ptr_reg];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;
  // Pointer advance with wrap at any depth
  function automatic logic [PW-1:0] nxt(input logic [PW-1:0] p);
    return (p == PW'(D - 1)) ? '0 : p + PW'(1);
  endfunction
  // Storage write, no reset needed for data
  always_ff @(posedge clk) begin
    if (push) begin
      buf_mem[wr_ptr_reg] <= in_s.data;
    end
  end
  // Pointers and count
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= nxt(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg <= nxt(rd_ptr_reg);
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + CW'(1);
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - CW'(1);
      end
    end
  end
endmodule

/* File: hw/dsp_sram_port.sv */
// Device side of a double-data-rate two-word burst SRAM port
module dsp_sram_port import dsp_pkg::*; #(
  parameter int DW = DW_X18,
  parameter int AW = DEF_AW,
  parameter int FD = FIFO_DEPTH
) (
  // System clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Input clock pair, sampled as pins
  input wire logic K_PIN,
  input wire logic KN_PIN,
  // Command pins
  input wire logic LOAD_SELECT_N,
  input wire logic READ_NOT_WRITE,
  input wire logic [AW-1:0] ADDR,
  // Byte masks and two-way data pins
  input wire logic [DW/LANE_W-1:0] BYTE_WRITE_SELECT_N,
  input wire logic [DW-1:0] DQ_IN,
  output logic [DW-1:0] DQ_OUT,
  output logic DQ_OE_N
);
  localparam int BW = DW / LANE_W; // Lanes per word
  localparam int IW = 4 + AW + BW + DW; // Sampled pin bundle width
  // Only the two documented organisations are served
  if (DW != DW_X18 && DW != DW_X36) begin : g_bad_width
    $error("dsp_sram_port: DW must be 18 or 36");
  end
  if (FD < 4) begin : g_bad_depth
    $error("dsp_sram_port: buffer must hold two bursts");
  end
  // ==========================================================
  // Pin synchronisers and edge detect
  // ==========================================================
  logic [IW-1:0] pin_s1_reg; // First stage, read only by second
  logic [IW-1:0] pin_s2_reg; // Second stage, safe to use
  logic k_d_reg; // Delayed true clock for edge detect
  logic kn_d_reg; // Delayed complement clock
  logic k_s, kn_s, load_select_n_s, rnw_s; // Unpacked sampled pins
  logic [AW-1:0] addr_s;
  logic [BW-1:0] byte_sel_n_s; // Sampled active-low lane selects
  logic [DW-1:0] dq_s;
  logic k_rise, kn_rise; // One-cycle edge enables
  // All pins share one delay, so data stays aligned to its edge
  always_ff @(posedge CLK) begin
    pin_s1_reg <= {K_PIN, KN_PIN, LOAD_SELECT_N, READ_NOT_WRITE, ADDR,
                   BYTE_WRITE_SELECT_N, DQ_IN};
    pin_s2_reg <= pin_s1_reg;
  end
  assign {k_s, kn_s, load_select_n_s, rnw_s, addr_s, byte_sel_n_s, dq_s} = pin_s2_reg;
  // Edge detect looks only at the second stage
  always_ff @(posedge CLK) begin
    if (RST) begin
      k_d_reg <= 1'b1;
      kn_d_reg <= 1'b1;
    end else begin
      k_d_reg <= k_s;
      kn_d_reg <= kn_s;
    end
  end
  // Stopped clocks give no edges, so below only a fetch already started still moves
  assign k_rise = k_s && !k_d_reg;
  assign kn_rise = kn_s && !kn_d_reg;
  // ==========================================================
  // Command decode
  // ==========================================================
  logic cmd_rd, cmd_wr; // Operation started at this K rise
  assign cmd_rd = k_rise && !load_select_n_s && rnw_s;
  assign cmd_wr = k_rise && !load_select_n_s && !rnw_s;
  // ==========================================================
  // Array and posted write register
  // ==========================================================
  logic [DW-1:0] mem [2**AW]; // Storage array
  logic pst_vld_reg; // Posted second word waiting
  logic [AW-1:0] pst_addr_reg; // Its address, A+1
  logic [DW-1:0] pst_data_reg; // Its data
  logic [BW-1:0] pst_mask_reg; // Its own lane selects
  // Replace only lanes whose select is low
  function automatic logic [DW-1:0] lane_merge(input logic [DW-1:0] old_w,
      input logic [DW-1:0] new_w, input logic [BW-1:0] sel_n);
    logic [DW-1:0] r;
    r = old_w;
    for (int i = 0; i < BW; i++) begin
      if (!sel_n[i]) begin
        r[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
      end
    end
    return r;
  endfunction
  // Newest value of a word, posted data taking precedence
  function automatic logic [DW-1:0] rd_word(input logic [AW-1:0] a);
    if (pst_vld_reg && pst_addr_reg == a) begin
      return lane_merge(mem[a], pst_data_reg, pst_mask_reg);
    end
    return mem[a];
  endfunction
  // ==========================================================
  // Write path
  // ==========================================================
  logic wr_vld_reg; // Command taken, first word due at next K
  logic wr_ph_reg; // First word taken, second due at K-bar
  logic [AW-1:0] wr_addr_reg; // Latched burst address
  // Write sequencing on K and K-bar rises
  always_ff @(posedge CLK) begin
    if (RST) begin
      wr_vld_reg <= 1'b0;
      wr_ph_reg <= 1'b0;
      wr_addr_reg <= '0;
    end else begin
      if (k_rise) begin
        wr_vld_reg <= cmd_wr;
        wr_ph_reg <= wr_vld_reg;
        if (cmd_wr) begin
          wr_addr_reg <= addr_s;
        end
      end else if (kn_rise) begin
        wr_ph_reg <= 1'b0;
      end
    end
  end
  // First word goes to the array; old posted word lands at the same edge
  always_ff @(posedge CLK) begin
    if (k_rise && wr_vld_reg) begin
      if (pst_vld_reg && pst_addr_reg != wr_addr_reg) begin
        mem[pst_addr_reg] <= lane_merge(mem[pst_addr_reg], pst_data_reg,
                                        pst_mask_reg);
      end
      // Folding the posted word keeps its lanes on an address match
      mem[wr_addr_reg] <= lane_merge(rd_word(wr_addr_reg), dq_s, byte_sel_n_s);
    end
  end
  // Second word is held posted until the next write's first word lands, a K after its command
  always_ff @(posedge CLK) begin
    if (RST) begin
      pst_vld_reg <= 1'b0;
      pst_addr_reg <= '0;
      pst_data_reg <= '0;
      pst_mask_reg <= '1;
    end else if (k_rise && wr_vld_reg) begin
      pst_vld_reg <= 1'b0;
      pst_addr_reg <= wr_addr_reg + AW'(1);
    end else if (kn_rise && wr_ph_reg) begin
      pst_vld_reg <= 1'b1;
      pst_data_reg <= dq_s;
      pst_mask_reg <= byte_sel_n_s;
    end
  end
  // ==========================================================
  // Read path
  // ==========================================================
  logic [RD_PIPE-1:0] rd_vld_reg; // Read age in K rises
  logic [AW-1:0] rd_addr_reg; // Latched read address
  logic [1:0] fch_cnt_reg; // Words still to fetch
  logic [AW-1:0] fch_addr_reg; // Word being fetched
  logic drive_edge; // A burst word leaves at this edge
  dsp_stream_if #(.W(DW)) fill_s ();
  dsp_stream_if #(.W(DW)) drain_s ();
  // Read age pipe, one step per K rise
  always_ff @(posedge CLK) begin
    if (RST) begin
      rd_vld_reg <= '0;
      rd_addr_reg <= '0;
    end else if (k_rise) begin
      rd_vld_reg <= {rd_vld_reg[RD_PIPE-2:0], cmd_rd};
      if (cmd_rd) begin
        rd_addr_reg <= addr_s;
      end
    end
  end
  // Fetch a K later so a write one cycle earlier is complete;
  // assumes K runs at a quarter of CLK or slower
  always_ff @(posedge CLK) begin
    if (RST) begin
      fch_cnt_reg <= '0;
      fch_addr_reg <= '0;
    end else if (k_rise && rd_vld_reg[0]) begin
      fch_cnt_reg <= BURST_WORDS;
      fch_addr_reg <= rd_addr_reg;
    end else if (fill_s.valid && fill_s.ready) begin
      fch_cnt_reg <= fch_cnt_reg - 2'h1;
      fch_addr_reg <= fch_addr_reg + AW'(1);
    end
  end
  assign fill_s.valid = (fch_cnt_reg != 2'h0);
  // Fetched word; a process so that array and posted changes re-evaluate it,
  // since a plain assign would only wake on a new fetch address
  always_comb begin
    fill_s.data = rd_word(fch_addr_reg);
  end
  // Word buffer between array fetch and pin launch
  dsp_fifo #(.W(DW), .D(FD)) u_rd_fifo (
    .clk(CLK),
    .rst(RST),
    .in_s(fill_s),
    .out_s(drain_s)
  );
  // Oldest read drives at K-bar t+2 and K t+3
  assign drive_edge = (k_rise || kn_rise) && rd_vld_reg[RD_PIPE-1];
  assign drain_s.ready = drive_edge;
  // ==========================================================
  // Data pin launch
  // ==========================================================
  // Launch on either rise; release only on a K-bar rise
  always_ff @(posedge CLK) begin
    if (RST) begin
      DQ_OUT <= '0;
      DQ_OE_N <= 1'b1;
    end else if (drive_edge) begin
      if (drain_s.valid) begin
        DQ_OUT <= drain_s.data;
      end
      DQ_OE_N <= 1'b0;
    end else if (kn_rise) begin
      DQ_OE_N <= 1'b1;
    end
  end
  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_rd_due;
    kn_rise && rd_vld_reg[RD_PIPE-1];
  endsequence
  sequence s_driving;
    !DQ_OE_N;
  endsequence
  a_rd_drive_on: assert property (s_rd_due |=> s_driving)
    else $error("read word not driven at K-bar rise");
  a_idle_release: assert property (kn_rise && !rd_vld_reg[RD_PIPE-1] |=> DQ_OE_N)
    else $error("data pins not released when idle");
  a_nop_nothing: assert property (k_rise && load_select_n_s |=> !rd_vld_reg[0]
      && !wr_vld_reg)
    else $error("deselected cycle started an operation");
  a_stop_hold: assert property (!k_rise && !kn_rise
      |=> $stable(DQ_OUT) && $stable(DQ_OE_N))
    else $error("data pins moved without a clock edge");
  a_fetch_burst: assert property (k_rise && rd_vld_reg[0] |=> fch_cnt_reg == 2'h2
      && fch_addr_reg == $past(rd_addr_reg))
    else $error("fetch not started at read address");
  a_fetch_step: assert property (fill_s.valid && fill_s.ready && !(k_rise && rd_vld_reg[0])
      |=> fch_addr_reg == $past(fch_addr_reg) + AW'(1))
    else $error("second burst word not at A plus one");
  a_lane0_write: assert property (k_rise && wr_vld_reg && !byte_sel_n_s[0]
      |=> mem[$past(wr_addr_reg)][LANE_W-1:0] == $past(dq_s[LANE_W-1:0]))
    else $error("selected lane not written");
  a_lane_keep: assert property (k_rise && wr_vld_reg && byte_sel_n_s[BW-1]
      && !(pst_vld_reg && pst_addr_reg == wr_addr_reg)
      |=> mem[$past(wr_addr_reg)][DW-1 -: LANE_W]
      == $past(mem[wr_addr_reg][DW-1 -: LANE_W]))
    else $error("masked lane altered");
  a_word2_posted: assert property (kn_rise && wr_ph_reg && !k_rise
      |=> pst_vld_reg && pst_mask_reg == $past(byte_sel_n_s)
      && pst_data_reg == $past(dq_s))
    else $error("second word not posted with its own mask");
  a_bypass_full: assert property (fill_s.valid && pst_vld_reg && pst_addr_reg == fch_addr_reg
      && pst_mask_reg == '0 |-> fill_s.data == pst_data_reg)
    else $error("read missed posted write data");
endmodule

/* File: dv/dsp_ctrl_model.sv */
// Controller model: input clock pair, commands and write words
module dsp_ctrl_model import dsp_pkg::*; #(
  parameter int DW = DW_X18,
  parameter int AW = DEF_AW
) (
  // System clock
  input wire logic clk,
  // Pins toward the port
  output logic k_pin,
  output logic kn_pin,
  output logic load_select_n,
  output logic rnw,
  output logic [AW-1:0] addr,
  output logic [DW/LANE_W-1:0] byte_write_select_n,
  output logic [DW-1:0] dq,
  output logic dq_en
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BW = DW / LANE_W; // Lane select count
  // ==========================================================
  // Idle levels: clocks steady so no spurious rise
  // ==========================================================
  initial begin
    k_pin = 1'b0;
    kn_pin = 1'b1;
    load_select_n = 1'b1;
    rnw = 1'b0;
    addr = '0;
    byte_write_select_n = '1;
    dq = '0;
    dq_en = 1'b0;
  end
  // One K period, 12 system cycles; inputs move 3 cycles off each rise.
  // Between calls the pair stands still with K low, K-bar high.
  task automatic slot(input logic l, input logic r, input logic [AW-1:0] a,
      input logic w, input logic [DW-1:0] d0, input logic [BW-1:0] m0,
      input logic [DW-1:0] d1, input logic [BW-1:0] m1);
    for (int ph = 0; ph < 12; ph++) begin
      @(posedge clk);
      if (ph == 0) begin
        // Command and first word ahead of K rise
        load_select_n <= l;
        rnw <= r;
        addr <= a;
        dq <= w ? d0 : ~dq;
        byte_write_select_n <= m0;
        dq_en <= w;
      end else if (ph == 3) begin
        k_pin <= 1'b1;
        kn_pin <= 1'b0;
      end else if (ph == 6) begin
        // Second word with its own mask; released bus keeps toggling
        load_select_n <= 1'b1;
        addr <= ~a;
        dq <= w ? d1 : ~dq;
        byte_write_select_n <= m1;
      end else if (ph == 9) begin
        k_pin <= 1'b0;
        kn_pin <= 1'b1;
      end
    end
  endtask
endmodule

/* File: dv/tb.sv */
// Self-checking bench for the double-data-rate burst SRAM port
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin \
  $display("BAD %s exp %h got %h", nm, e, s); error_cnt++; end end
module tb import dsp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DW = DW_X18; // Narrow organisation
  localparam int AW = 6; // Small array, wrap reachable
  localparam int BW = DW / LANE_W;
  // ==========================================================
  // Signals
  // ==========================================================
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic k, kn, load_select_n, rnw, c_en, oe_n, k_q = 1'b0, kn_q = 1'b1;
  logic [AW-1:0] addr;
  logic [BW-1:0] byte_write_select_n, pm0, pm1;
  logic [DW-1:0] c_dq, dq_in, dq_out, pd0, pd1, ev, sv_q;
  logic pw = 1'b0; // Write words owed in next slot
  logic [4:0] rise_sr = '0; // Pin rises awaiting settle
  logic [DW-1:0] ref_m [0:63]; // Expected array content
  logic [DW-1:0] exp_q [$]; // Read words still due
  int error_cnt = 0, n_tests = 0, cyc = 0, since = 2, kind;
  always #5 clk = ~clk;
  // Wire level: controller, else device, else released pattern
  assign dq_in = (c_en || oe_n) ? c_dq : dq_out;
  dsp_ctrl_model #(.DW(DW), .AW(AW)) ctrl_u (.clk(clk), .k_pin(k), .kn_pin(kn),
    .load_select_n(load_select_n), .rnw(rnw), .addr(addr),
    .byte_write_select_n(byte_write_select_n), .dq(c_dq), .dq_en(c_en));
  dsp_sram_port #(.DW(DW), .AW(AW), .FD(FIFO_DEPTH)) dut_u (.CLK(clk), .RST(rst),
    .K_PIN(k), .KN_PIN(kn), .LOAD_SELECT_N(load_select_n), .READ_NOT_WRITE(rnw),
    .ADDR(addr), .BYTE_WRITE_SELECT_N(byte_write_select_n), .DQ_IN(dq_in), .DQ_OUT(dq_out),
    .DQ_OE_N(oe_n));
  // Lane merge: low select takes the new lane
  function automatic logic [DW-1:0] merge(logic [DW-1:0] o, logic [DW-1:0] n,
      logic [BW-1:0] m);
    for (int i = 0; i < BW; i++)
      if (!m[i]) o[i*LANE_W +: LANE_W] = n[i*LANE_W +: LANE_W];
    return o;
  endfunction
  // One slot: new command plus words owed by the previous write
  task automatic op(input logic l, input logic r, input logic [AW-1:0] a,
      input logic [BW-1:0] m0, input logic [BW-1:0] m1);
    logic [DW-1:0] d0, d1;
    d0 = DW'($urandom());
    d1 = DW'($urandom());
    if (!l && r) begin
      exp_q.push_back(ref_m[a]);
      exp_q.push_back(ref_m[a + 1'b1]);
    end else if (!l) begin
      // Newest data seen at once, posted or not
      ref_m[a] = merge(ref_m[a], d0, m0);
      ref_m[a + 1'b1] = merge(ref_m[a + 1'b1], d1, m1);
    end
    since = (!l && r) ? 0 : since + 1;
    ctrl_u.slot(l, r, a, pw, pd0, pm0, pd1, pm1);
    pw = !l && !r;
    {pd0, pd1, pm0, pm1} = {d0, d1, m0, m1};
  endtask
  // Verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ==========================================================
  // Watcher: 6 cycles after each pin rise a driven word is due
  // ==========================================================
  always @(posedge clk) begin
    k_q <= k;
    kn_q <= kn;
    rise_sr <= {rise_sr[3:0], (k & !k_q) | (kn & !kn_q)};
    cyc <= cyc + 1;
    if (rise_sr[4] && oe_n !== 1'b1) begin
      // Both clock rises launch words, in burst order
      ev = (exp_q.size() > 0) ? exp_q.pop_front() : ~dq_out;
      `CHK("read word", ev, dq_out)
    end
    if (cyc == 30000) begin
      // Hang cut short
      error_cnt++;
      report_and_stop();
    end
  end
  // ==========================================================
  // Stimulus
  // ==========================================================
  initial begin
    void'($urandom(32'hC8BA798C));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK("oe after reset", 1'b1, oe_n)
    $display("test reset done");
    // Fill the array with back-to-back writes, wrap at the top
    for (int a = 1; a < 64; a += 2) op(1'b0, 1'b0, AW'(a), '0, '0);
    $display("test fill done");
    // Every mask, different per word, then read straight after
    for (int m = 0; m < 4; m++) begin
      kind = $urandom_range(63);
      op(1'b0, 1'b0, AW'(kind), BW'(m), ~BW'(m));
      op(1'b0, 1'b1, AW'(kind), '0, '0);
      op(1'b1, 1'b0, '0, '0, '0);
      op(1'b1, 1'b0, '0, '0, '0);
    end
    $display("test masks done");
    // Random mix; writes wait two idle slots after a read
    for (int i = 0; i < 60; i++) begin
      kind = $urandom_range(2);
      if (kind == 1 && since < 2) kind = 0;
      op(kind == 0, kind == 2, AW'($urandom()), BW'($urandom()), BW'($urandom()));
    end
    repeat (3) op(1'b1, 1'b0, '0, '0, '0);
    $display("test random done");
    // Stop the clocks in mid burst; pins must hold
    op(1'b0, 1'b1, 6'h3F, '0, '0);
    repeat (2) op(1'b1, 1'b0, '0, '0, '0);
    repeat (8) @(posedge clk);
    sv_q = dq_out;
    repeat (30) @(posedge clk);
    `CHK("held word", sv_q, dq_out)
    `CHK("held enable", 1'b0, oe_n)
    repeat (3) op(1'b1, 1'b0, '0, '0, '0);
    `CHK("words left", 0, exp_q.size())
    $display("test stop done");
    report_and_stop();
  end
endmodule
